// ### hw/touch_button_output_control.sv
// Purpose: output control of a ten channel touch button controller
// Assumes: touch detection and self-test run elsewhere; their flags are inputs
// Notes:   strap levels are classified outside; this block decodes them once
//
// How it works
// - straps sensed once after reset, settings decoded
// - grounded touch input never drives output
// - ten channels, indices zero to nine
// - each output follows its own input; under suppression the other inputs also count
// - output low while reported on, else high
// - failed self-test: one 5 ms pulse
// - toggle mode: each touch inverts held output
// - suppression, single detection: that button on
// - suppression, several: only previous one stays
// - 5.1k: suppression only; supply: toggle and suppression
// - 1.5k: autoreset normal; supply: autoreset high noise
// - 1.5k: effect one; ground: analog mode
// - backlight driven only in analog mode
// - 1.8k: 1000 ms on-time; ground: none
// - 8.8k: 298 ms scan; 8.3k: 210 ms
// - on-time after release, 20 ms steps
// - continuous touch released after 20 s
// - input shorted to ground at self-test disabled
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module touch_button_output_control
   import touch_output_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYCLES_DEF
) (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   // straps and sensing front end
   input  wire strap_type         strapLevels,
   input  wire logic [NCH-1:0]    touchDetected,
   input  wire logic [NCH-1:0]    inputGrounded,
   input  wire logic [NCH-1:0]    selfTestFail,
   // button, backlight and interrupt pins
   output logic      [NCH-1:0]    buttonOutN,
   output logic                   backlightOutN,
   output logic                   backlightOeN,
   output logic                   irq,
   // avalon-mm slave
   input  wire logic [4:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest
);
   localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_CYCLES - 1);

   phase_type            state_ff;
   cfg_type              cfg_ff;
   logic [MS_W-1:0]      msCnt_ff;
   logic                 msTick;
   logic [10:0]          phaseMs_ff;
   logic [10:0]          postLast;
   logic [NCH-1:0]       enMask_ff;
   logic [NCH-1:0]       failMask_ff;
   logic [NCH-1:0]       chanEn_ff;
   logic [NCH-1:0]       det;
   logic [NCH-1:0]       active;
   logic                 single;
   logic [NCH-1:0]       nxt_rep;
   logic [NCH-1:0]       rep_ff;
   logic [NCH-1:0]       pressVec;
   logic [NCH-1:0]       releaseVec;
   logic [NCH-1:0]       held_ff;
   logic [NCH-1:0]       arTrip_ff;
   logic [NCH-1:0]       arNew;
   logic [NCH-1:0]       holdMask_ff;
   logic [10:0]          holdMs_ff;
   logic [NCH-1:0]       nxt_low;
   logic [NCH-1:0]       buttonOutN_ff;
   logic                 backlightOutN_ff;
   logic                 backlightOeN_ff;
   logic [3:0]           irqStatus_ff;
   logic [3:0]           irqMask_ff;
   logic [3:0]           events;
   logic                 irq_ff;
   logic [31:0]          readdata_ff;
   logic                 waitreq_ff;
   logic [31:0]          nxt_readdata;
   logic                 wrDone;
   logic [15:0]          laneMask;

   assign buttonOutN      = buttonOutN_ff;
   assign backlightOutN   = backlightOutN_ff;
   assign backlightOeN    = backlightOeN_ff;
   assign irq             = irq_ff;
   assign avs_readdata    = readdata_ff;
   assign avs_waitrequest = waitreq_ff;

   // decode of the classified strap levels; unlisted levels fall back to off
   function automatic cfg_type decode_straps(input strap_type s);
      cfg_type c;
      c = '0;
      case (s.toggleSuppress)
         STRAP_R5K1: c.flankSuppression = 1'b1;
         STRAP_VDD: begin
            c.toggleMode       = 1'b1;
            c.flankSuppression = 1'b1;
         end
         default: c.flankSuppression = 1'b0;
      endcase
      case (s.autoresetNoise)
         STRAP_R1K5: c.stuckTouchRelease = 1'b1;
         STRAP_VDD: begin
            c.stuckTouchRelease = 1'b1;
            c.noiseHigh         = 1'b1;
         end
         default: c.stuckTouchRelease = 1'b0;
      endcase
      case (s.ledEffect)
         STRAP_R1K5: c.effectSeq = 2'h1;
         STRAP_GND:  c.analogMode = 1'b1;
         default:    c.effectSeq = 2'h0;
      endcase
      c.onTimeEn    = (s.releaseDelay == STRAP_R1K8);
      c.serialDebug = 1'b0;
      c.scanSlow    = (s.scanPeriod == STRAP_R8K8);
      c.lowSense    = (s.firstButtonSense == STRAP_VDD);
      return c;
   endfunction

   // millisecond time base; long counts stay in ms so the cycle count is small
   assign msTick = (msCnt_ff == MS_LAST);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         msCnt_ff <= '0;
      end else if (msTick) begin
         msCnt_ff <= '0;
      end else begin
         msCnt_ff <= msCnt_ff + 1'b1;
      end
   end

   assign postLast = cfg_ff.noiseHigh ? 11'(POST_HIGH_MS - 1) : 11'(POST_NORMAL_MS - 1);

   // power-on sequence: capture straps, wait, diagnostic pulse, run
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_ff    <= ST_CAPTURE;
         phaseMs_ff  <= '0;
         cfg_ff      <= '0;
         enMask_ff   <= '0;
         failMask_ff <= '0;
      end else begin
         case (state_ff)
            ST_CAPTURE: begin
               cfg_ff      <= decode_straps(strapLevels);
               enMask_ff   <= ~inputGrounded & ~selfTestFail;
               failMask_ff <= selfTestFail & ~inputGrounded;
               phaseMs_ff  <= '0;
               state_ff    <= ST_WAIT;
            end
            ST_WAIT: begin
               if (msTick) begin
                  if (phaseMs_ff == postLast) begin
                     phaseMs_ff <= '0;
                     state_ff   <= ST_PULSE;
                  end else begin
                     phaseMs_ff <= phaseMs_ff + 1'b1;
                  end
               end
            end
            ST_PULSE: begin
               if (msTick) begin
                  if (phaseMs_ff == 11'(PULSE_MS - 1)) begin
                     phaseMs_ff <= '0;
                     state_ff   <= ST_RUN;
                  end else begin
                     phaseMs_ff <= phaseMs_ff + 1'b1;
                  end
               end
            end
            ST_RUN:  state_ff <= ST_RUN;
            default: state_ff <= ST_CAPTURE;
         endcase
      end
   end

   // detection gated per channel, then flank suppression
   assign det    = touchDetected & enMask_ff & chanEn_ff & {NCH{state_ff == ST_RUN}};
   assign active = det & ~arTrip_ff;
   assign single = (active != '0) && ((active & (active - 1'b1)) == '0);
   always_comb begin
      if (!cfg_ff.flankSuppression || single) begin
         nxt_rep = active;
      end else begin
         nxt_rep = rep_ff & active;
      end
   end
   assign pressVec   = nxt_rep & ~rep_ff;
   assign releaseVec = rep_ff & ~nxt_rep & ~arTrip_ff & ~arNew;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rep_ff  <= '0;
         held_ff <= '0;
      end else begin
         rep_ff  <= nxt_rep;
         held_ff <= held_ff ^ (pressVec & {NCH{cfg_ff.toggleMode}});
      end
   end

   // per channel auto release of a stuck touch
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_ch
         logic [14:0] touchMs_ff;
         // one tick past the period: the first tick may land anywhere in the first ms
         assign arNew[gi] = msTick && touchMs_ff == 15'(AUTORESET_MS) && !arTrip_ff[gi];
         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               touchMs_ff    <= '0;
               arTrip_ff[gi] <= 1'b0;
            end else if (!cfg_ff.stuckTouchRelease || !det[gi]) begin
               touchMs_ff    <= '0;
               arTrip_ff[gi] <= 1'b0;
            end else if (arNew[gi]) begin
               arTrip_ff[gi] <= 1'b1;
            end else if (msTick && !arTrip_ff[gi]) begin
               touchMs_ff <= touchMs_ff + 1'b1;
            end
         end
      end
   endgenerate

   // on-time after release, only for the most recently released button
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         holdMask_ff <= '0;
         holdMs_ff   <= '0;
      end else if (releaseVec != '0 && cfg_ff.onTimeEn && !cfg_ff.toggleMode) begin
         holdMask_ff <= releaseVec;
         holdMs_ff   <= '0;
      end else if (holdMask_ff != '0 && msTick) begin
         if (holdMs_ff == 11'(ONTIME_MS)) begin                   // never short of the on-time
            holdMask_ff <= '0;
            holdMs_ff   <= '0;
         end else begin
            holdMs_ff <= holdMs_ff + 1'b1;
         end
      end
   end

   always_comb begin
      if (state_ff == ST_PULSE) begin
         nxt_low = failMask_ff;
      end else if (state_ff != ST_RUN) begin
         nxt_low = '0;
      end else if (cfg_ff.toggleMode) begin
         nxt_low = held_ff & enMask_ff & chanEn_ff;
      end else begin
         nxt_low = rep_ff | (holdMask_ff & ~nxt_rep & ~active);
      end
   end

   // active low pins; backlight only exists in analog mode
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         buttonOutN_ff    <= '1;
         backlightOutN_ff <= 1'b1;
         backlightOeN_ff  <= 1'b1;
      end else begin
         buttonOutN_ff    <= ~nxt_low;
         backlightOutN_ff <= ~(cfg_ff.analogMode && rep_ff != '0);
         backlightOeN_ff  <= ~cfg_ff.analogMode;
      end
   end

   // sticky events, set wins over a write-one clear in the same cycle
   assign events[EV_POST_DONE] = (state_ff == ST_PULSE) && msTick && phaseMs_ff == 11'(PULSE_MS - 1);
   assign events[EV_POST_FAIL] = (state_ff == ST_CAPTURE) && ((selfTestFail & ~inputGrounded) != '0);
   assign events[EV_PRESS]     = pressVec != '0;
   assign events[EV_AUTOREL]   = arNew != '0;
   assign wrDone   = avs_write && !waitreq_ff;
   assign laneMask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irqStatus_ff <= '0;
      end else if (wrDone && avs_address == ADDR_IRQ_STATUS) begin
         irqStatus_ff <= (irqStatus_ff & ~(avs_writedata[3:0] & laneMask[3:0])) | events;
      end else begin
         irqStatus_ff <= irqStatus_ff | events;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irqMask_ff <= IRQ_MASK_RST;
         chanEn_ff  <= CHAN_EN_RST;
      end else if (wrDone) begin
         if (avs_address == ADDR_IRQ_MASK) begin
            irqMask_ff <= (irqMask_ff & ~laneMask[3:0]) | (avs_writedata[3:0] & laneMask[3:0]);
         end
         if (avs_address == ADDR_CHAN_EN) begin
            chanEn_ff <= (chanEn_ff & ~laneMask[9:0]) | (avs_writedata[9:0] & laneMask[9:0]);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= (irqStatus_ff & irqMask_ff) != '0;
      end
   end

   // one wait cycle per access; unmapped addresses read zero
   always_comb begin
      case (avs_address)
         ADDR_CFG_STATUS: nxt_readdata = {18'h0, state_ff, 1'b0, cfg_ff};
         ADDR_BUTTONS:    nxt_readdata = {6'h0, enMask_ff, 6'h0, ~buttonOutN_ff};
         ADDR_CHAN_EN:    nxt_readdata = {22'h0, chanEn_ff};
         ADDR_IRQ_STATUS: nxt_readdata = {28'h0, irqStatus_ff};
         ADDR_IRQ_MASK:   nxt_readdata = {28'h0, irqMask_ff};
         default:         nxt_readdata = 32'h0;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         waitreq_ff  <= 1'b1;
         readdata_ff <= 32'h0;
      end else begin
         waitreq_ff <= !((avs_read || avs_write) && waitreq_ff);
         if (avs_read && waitreq_ff) begin
            readdata_ff <= nxt_readdata;
         end
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   sequence post_wait_end;
      state_ff == ST_WAIT && msTick && phaseMs_ff == postLast;
   endsequence
   sequence pulse_on;
      state_ff == ST_PULSE ##1 buttonOutN_ff == ~failMask_ff;
   endsequence

   pulseStart_a: assert property (post_wait_end |=> pulse_on)
      else $error("diagnostic pulse did not follow the power-on wait");
   pulseLen_a: assert property (state_ff == ST_PULSE |-> phaseMs_ff < 11'(PULSE_MS))
      else $error("diagnostic pulse ran past its length");
   disabledQuiet_a: assert property (state_ff == ST_RUN && $past(state_ff) == ST_RUN
      |-> (~enMask_ff & ~buttonOutN_ff) == '0)
      else $error("disabled channel drove its output");
   strapHold_a: assert property (state_ff != ST_CAPTURE && $past(state_ff) != ST_CAPTURE |-> $stable(cfg_ff))
      else $error("decoded settings changed after capture");
   activeLow_a: assert property (!cfg_ff.toggleMode && rep_ff != '0 && state_ff == ST_RUN
      |=> (buttonOutN_ff & $past(rep_ff)) == '0)
      else $error("reported button output not low");
   fssSingle_a: assert property (cfg_ff.flankSuppression && single |=> rep_ff == $past(active))
      else $error("single detection not reported");
   fssMulti_a: assert property (cfg_ff.flankSuppression && !single && active != '0
      |=> (rep_ff & ~$past(rep_ff)) == '0)
      else $error("new button reported while others held");
   toggleFlip_a: assert property (cfg_ff.toggleMode && state_ff == ST_RUN && pressVec != '0
      ##1 state_ff == ST_RUN |=> ((buttonOutN_ff ^ $past(buttonOutN_ff)) & $past(pressVec, 2)) == $past(pressVec, 2))
      else $error("toggle did not invert held output");
   backlightOff_a: assert property (!cfg_ff.analogMode |=> backlightOeN_ff && backlightOutN_ff)
      else $error("backlight driven outside analog mode");
   autoRelease_a: assert property ((arTrip_ff & $past(arTrip_ff) & rep_ff) == '0)
      else $error("stuck touch still reported after release");
   onTimeBound_a: assert property (holdMask_ff != '0 |-> holdMs_ff <= 11'(ONTIME_MS))
      else $error("on-time counter overran");
   irqLevel_a: assert property (##1 irq_ff == ($past(irqStatus_ff & irqMask_ff) != '0))
      else $error("interrupt output does not follow masked status");
endmodule

// ### hw/touch_output_pkg.sv
// Purpose: shared constants and types for the touch button output control block
// Assumes: 200 MHz system clock, strap levels arrive already classified
// Notes:   times are kept in ms; cycle counts derive from the clock period
package touch_output_pkg;
   // clock and time base
   localparam int CLK_PERIOD_PS  = 5000;
   localparam int MS_PS          = 1000000000;
   localparam int MS_CYCLES_DEF  = MS_PS / CLK_PERIOD_PS;
   localparam int MS_W           = 18;
   // feature times in ms, channel count
   localparam int PULSE_MS       = 5;
   localparam int POST_NORMAL_MS = 350;
   localparam int POST_HIGH_MS   = 1000;
   localparam int STEP_MS        = 20;
   localparam int ONTIME_STEPS   = 50;
   localparam int ONTIME_MS      = STEP_MS * ONTIME_STEPS;
   localparam int AUTORESET_MS   = 20000;
   localparam int SCAN_SLOW_MS   = 298;
   localparam int SCAN_FAST_MS   = 210;
   localparam int NCH            = 10;
   // classified strap levels
   typedef enum logic [2:0] {
      STRAP_GND = 3'h0, STRAP_VDD = 3'h1, STRAP_R1K5 = 3'h2, STRAP_R1K8 = 3'h3,
      STRAP_R5K1 = 3'h4, STRAP_R8K3 = 3'h5, STRAP_R8K8 = 3'h6, STRAP_OPEN = 3'h7
   } strap_level_type;
   typedef struct packed {
      strap_level_type toggleSuppress;
      strap_level_type autoresetNoise;
      strap_level_type ledEffect;
      strap_level_type releaseDelay;
      strap_level_type firstButtonSense;
      strap_level_type scanPeriod;
   } strap_type;
   typedef struct packed {
      logic       lowSense;
      logic       scanSlow;
      logic       serialDebug;
      logic       onTimeEn;
      logic [1:0] effectSeq;
      logic       analogMode;
      logic       noiseHigh;
      logic       stuckTouchRelease;
      logic       flankSuppression;
      logic       toggleMode;
   } cfg_type;
   typedef enum logic [1:0] {
      ST_CAPTURE = 2'b00, ST_WAIT = 2'b01, ST_PULSE = 2'b11, ST_RUN = 2'b10
   } phase_type;
   // register map, byte addresses
   localparam logic [4:0]  ADDR_CFG_STATUS = 5'h00;
   localparam logic [4:0]  ADDR_BUTTONS    = 5'h04;
   localparam logic [4:0]  ADDR_CHAN_EN    = 5'h08;
   localparam logic [4:0]  ADDR_IRQ_STATUS = 5'h0C;
   localparam logic [4:0]  ADDR_IRQ_MASK   = 5'h10;
   localparam logic [9:0]  CHAN_EN_RST     = 10'h3FF;
   localparam logic [3:0]  IRQ_MASK_RST    = 4'h0;
   // interrupt event bits
   localparam int EV_POST_DONE = 0;
   localparam int EV_POST_FAIL = 1;
   localparam int EV_PRESS     = 2;
   localparam int EV_AUTOREL   = 3;
endpackage

// ### testbench/led_load.sv
// Purpose: far-side load on the button and backlight pins
// Assumes: every pin carries a pull-up resistor to supply
// Notes:   a pin whose driver is off reads as the pull-up level
`timescale 1ns/1ps
module led_load
   import touch_output_pkg::*;
(
   // pins from the block
   input  wire logic [NCH-1:0] buttonOutN,
   input  wire logic           backlightOutN,
   input  wire logic           backlightOeN,
   // what the far side sees
   output logic      [NCH-1:0] ledLit,
   output logic                backlightLit
);
   logic backlightPin;

   // strong drive on button pins, led lit while pulled low
   assign ledLit = ~buttonOutN;
   // released backlight floats to the pull-up, so its led stays dark
   assign backlightPin = backlightOeN ? 1'b1 : backlightOutN;
   assign backlightLit = ~backlightPin;
endmodule

// ### testbench/test_touch_button_output_control.sv
// Purpose: self-checking bench for the touch button output control block
// Assumes: one ms is shortened to MSC clock cycles
// Notes:   ms kept very short so the 20 s stuck-touch release fits the run
`timescale 1ns/1ps
module test_touch_button_output_control;
   import touch_output_pkg::*;
   localparam int MSC = 2;
   logic              clk_sys;
   logic              rst_b;
   strap_type         strapLevels;
   logic [NCH-1:0]    touchDetected;
   logic [NCH-1:0]    inputGrounded;
   logic [NCH-1:0]    selfTestFail;
   logic [NCH-1:0]    buttonOutN;
   logic [NCH-1:0]    ledLit;
   logic              backlightOutN;
   logic              backlightOeN;
   logic              backlightLit;
   logic              irq;
   logic [4:0]        avs_address;
   logic              avs_read;
   logic              avs_write;
   logic              avs_waitrequest;
   logic [31:0]       avs_writedata;
   logic [31:0]       avs_readdata;
   logic [31:0]       expQ[$];
   logic [7:0]        rnd;
   int                n_errors;
   int                checks;
   int                cyc;
   int                n;
   strap_type cfgA = strap_type'{STRAP_R5K1, STRAP_R1K5, STRAP_R1K5, STRAP_R1K8, STRAP_VDD, STRAP_R8K8};
   strap_type cfgB = strap_type'{STRAP_VDD, STRAP_VDD, STRAP_GND, STRAP_GND, STRAP_VDD, STRAP_R8K3};

   touch_button_output_control #(.MS_CYCLES(MSC)) DUT (
      .clk_sys(clk_sys), .rst_b(rst_b), .strapLevels(strapLevels), .touchDetected(touchDetected),
      .inputGrounded(inputGrounded), .selfTestFail(selfTestFail), .buttonOutN(buttonOutN),
      .backlightOutN(backlightOutN), .backlightOeN(backlightOeN), .irq(irq),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));

   led_load LOAD (.buttonOutN(buttonOutN), .backlightOutN(backlightOutN), .backlightOeN(backlightOeN),
      .ledLit(ledLit), .backlightLit(backlightLit));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cyc <= rst_b ? cyc + 1 : 0;
   end

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // read data are taken here at the edge where waitrequest is seen low
   always @(posedge clk_sys) begin
      if (avs_read && avs_waitrequest === 1'b0) begin
         if (expQ.size() == 0)
            cmp(avs_readdata, 32'hFFFFFFFF);
         else
            cmp(avs_readdata, expQ.pop_front());
      end
   end

   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int i;
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= ~wr;
      avs_write     <= wr;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_sys);
         if (avs_waitrequest === 1'b0)
            break;
      end
      if (i == 50) begin
         n_errors++;
         wrap_up();
      end
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      expQ.push_back(exp);
      bus(1'b0, a, 32'h0);
   endtask

   task automatic wait_out(input int ch, input logic v, input int lim, output int k);
      for (k = 0; k < lim && buttonOutN[ch] !== v; k++)
         @(posedge clk_sys);
      if (k == lim) begin
         n_errors++;
         wrap_up();
      end
   endtask

   task automatic do_reset(input strap_type s, input logic [NCH-1:0] fail);
      rst_b         <= 1'b0;
      strapLevels   <= s;
      selfTestFail  <= fail;
      touchDetected <= '0;
      repeat (8) @(posedge clk_sys);
      cmp({buttonOutN, irq, avs_waitrequest, backlightOeN}, {10'h3FF, 3'b011});
      rst_b <= 1'b1;
      @(posedge clk_sys);
   endtask

   task automatic touch(input logic [NCH-1:0] t);
      touchDetected <= t;
      repeat (3) @(posedge clk_sys);
   endtask

   initial begin
      rst_b = 1'b0;
      strapLevels = cfgA;
      touchDetected = '0;
      inputGrounded = 10'h100;
      selfTestFail = 10'h008;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      n_errors = 0;
      checks = 0;
      cyc = 0;
      rnd = 8'h2C;
      @(posedge clk_sys);
      do_reset(cfgA, 10'h008);
      rd(ADDR_CFG_STATUS, 32'h000016A6);
      wait_out(3, 1'b0, 1100 * MSC, n);
      cmp({31'h0, cyc >= POST_NORMAL_MS * MSC && cyc <= (POST_NORMAL_MS + 1) * MSC + 4}, 32'h1);
      cmp({30'h0, buttonOutN[8], buttonOutN[2]}, 32'h3);
      wait_out(3, 1'b1, 200, n);
      cmp({31'h0, n >= PULSE_MS * MSC - 1 && n <= PULSE_MS * MSC + 1}, 32'h1);
      repeat (4) @(posedge clk_sys);
      // interrupt: sticky post events, masking and write-one-to-clear
      rd(ADDR_IRQ_STATUS, 32'h3);
      cmp({31'h0, irq}, 32'h0);
      bus(1'b1, ADDR_IRQ_MASK, 32'h1);
      repeat (2) @(posedge clk_sys);
      cmp({31'h0, irq}, 32'h1);
      bus(1'b1, ADDR_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge clk_sys);
      cmp({31'h0, irq}, 32'h0);
      rd(ADDR_IRQ_STATUS, 32'h2);
      rd(5'h14, 32'h0);
      rnd = lfsr(rnd);
      bus(1'b1, ADDR_CHAN_EN, {4{rnd}});
      rd(ADDR_CHAN_EN, {22'h0, rnd[1:0], rnd});
      bus(1'b1, ADDR_CHAN_EN, 32'h3FF);
      strapLevels <= cfgB;
      rd(ADDR_CFG_STATUS, 32'h000026A6);
      touch(10'h002);
      cmp({22'h0, ledLit}, 32'h002);
      touch(10'h006);
      cmp({22'h0, ledLit}, 32'h002);
      cmp({31'h0, backlightLit}, 32'h0);
      touchDetected <= '0;
      @(posedge clk_sys);
      wait_out(1, 1'b1, (ONTIME_MS + 5) * MSC, n);
      cmp({31'h0, n >= ONTIME_MS * MSC && n <= (ONTIME_MS + 1) * MSC + 2}, 32'h1);
      touch(10'h108);
      cmp({22'h0, ledLit}, 32'h0);
      touch(10'h000);
      // stuck touch: released after the auto reset period, no on-time afterwards
      touchDetected <= 10'h001;
      wait_out(0, 1'b0, 10, n);
      wait_out(0, 1'b1, (AUTORESET_MS + 2) * MSC, n);
      cmp({31'h0, n >= AUTORESET_MS * MSC && n <= (AUTORESET_MS + 1) * MSC + 4}, 32'h1);
      rd(ADDR_IRQ_STATUS, 32'hE);
      touch(10'h000);
      cmp({22'h0, ledLit}, 32'h0);
      // second configuration: toggle, high noise, analog mode
      do_reset(cfgB, 10'h000);
      rd(ADDR_CFG_STATUS, 32'h0000141F);
      repeat ((POST_HIGH_MS + PULSE_MS + 2) * MSC) @(posedge clk_sys);
      touch(10'h010);
      cmp({21'h0, backlightLit, ledLit}, 32'h410);
      touch(10'h000);
      cmp({22'h0, ledLit}, 32'h010);
      touch(10'h010);
      cmp({21'h0, backlightLit, ledLit}, 32'h400);
      touch(10'h000);
      wrap_up();
   end
endmodule
